//--- dv/dmc_dimm_model.sv
// Behavioural model of the DIMM row pairs that sit behind the clock enables.
`timescale 1ns/1ps
module dmc_dimm_model #(
    parameter int N = 4
) (
    // Clock and per-pair controls.
    input  wire logic         clock,
    input  wire logic [N-1:0] want,
    input  wire logic [N-1:0] cke,
    input  wire logic [N-1:0] ready,
    // Pair status towards the controller.
    output logic      [N-1:0] banks_idle,
    output logic      [N-1:0] access_req,
    output int                late_use
);
    logic [N-1:0] open_r = '0;
    // A row opens only on an awake pair; an open row on a sleeping pair is counted as misuse.
    always_ff @(posedge clock) begin
        open_r   <= want & ready & cke;
        late_use <= late_use + $countones(open_r & ~cke);
    end
    // Banks read busy while a request is held, so the pair never sleeps under it.
    assign banks_idle = ~(open_r | want);
    assign access_req = want;
endmodule

//--- dv/tb.sv
// Self-checking testbench of the DRAM mode control block.
`timescale 1ns/1ps
module tb;
    logic        clock = 0, arst_n = 0, wr_en = 0, rd_en = 0, single = 0, rd_d = 0, ce = 1;
    logic [7:0]  addr = 0;
    logic [3:0]  be = 0, want = 0, cke, rdy, idle, areq;
    logic [31:0] wd = 0, rdata, mreg = dmc_pkg::MODE_RESET;
    logic        rdone = 0, rded = 0, actr = 0, cbusy = 0, colr = 0, colw = 0, hit = 0, cev = 0, uev = 0;
    logic        retry, hold, fatal, grant, apv, apf, cor, lce, lue;
    logic [1:0]  imode;
    logic [10:0] lmode;
    logic [31:0] q[4][$];
    int          bad_count = 0, total_checks = 0, cyc = 0, late;

    // The clock runs at 50 MHz.
    always #10 clock = ~clock;

    dmc_mode_ctrl i_dut (.clock(clock), .arst_n(arst_n), .ce(ce), .cfg_wr_en(wr_en), .cfg_rd_en(rd_en),
        .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wd), .cfg_rdata(rdata), .lower_mode(lmode), .single_channel(single),
        .pair_banks_idle(idle), .pair_access_req(areq), .pair_cke(cke), .pair_ready(rdy), .rd_done(rdone),
        .rd_ded(rded), .retry_req(retry), .read_hold(hold), .ded_fatal(fatal), .act_req(actr), .col_busy(cbusy),
        .act_grant(grant), .col_req(colr), .col_write(colw), .row_hit_pending(hit), .ap_valid(apv),
        .ap_flag(apf), .ecc_ce_evt(cev), .ecc_ue_evt(uev), .integ_mode(imode), .ecc_correct_en(cor),
        .log_ce(lce), .log_ue(lue));
    dmc_dimm_model i_dimm (.clock(clock), .want(want), .cke(cke), .ready(rdy), .banks_idle(idle),
        .access_req(areq), .late_use(late));

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // A result with no note waiting counts as a mismatch, which catches refused events that still fire.
    task automatic take(int k, string n, logic [31:0] g);
        if (q[k].size() == 0) chk(n, 'x, g);
        else chk(n, q[k].pop_front(), g);
    endtask
    task automatic end_sim();
        // A note never matched by a result means an output that did not appear.
        for (int k = 0; k < 4; k++)
            if (q[k].size() != 0) begin
                bad_count++;
                $display("CHECK FAILED queue%0d expected 0 notes left seen %0d", k, q[k].size());
            end
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Watcher: outputs are sampled at the edge, before that edge's updates land.
    always @(posedge clock) begin
        if (rd_d) take(0, "rdata", rdata);
        if (apv === 1'b1) take(1, "ap_flag", {31'h0, apf});
        if ((retry | fatal) === 1'b1) take(2, "retry_fatal", {30'h0, retry, fatal});
        if ((lce | lue) === 1'b1) take(3, "log", {30'h0, lce, lue});
        rd_d <= rd_en;
        cyc  <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic tick(int n = 1);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(logic [7:0] a, logic [3:0] b, logic [31:0] d);
        wr_en <= 1'b1; addr <= a; be <= b; wd <= d;
        for (int i = 0; i < 4; i++)
            if (a[7:2] == 6'h1f && b[i]) mreg[8*i+:8] = d[8*i+:8] & dmc_pkg::MODE_WR_MASK[8*i+:8];
        tick();
        wr_en <= 1'b0;
        tick();
    endtask
    task automatic rd(logic [7:0] a);
        rd_en <= 1'b1; addr <= a;
        q[0].push_back(a[7:2] == 6'h1f ? mreg : 32'h0);
        tick();
        rd_en <= 1'b0;
        tick();
    endtask
    task automatic col(logic w, logic h, logic e);
        colr <= 1'b1; colw <= w; hit <= h;
        q[1].push_back({31'h0, e});
        tick();
        colr <= 1'b0;
        tick();
    endtask
    task automatic rdev(logic d, logic [1:0] e);
        rdone <= 1'b1; rded <= d;
        if (e != 2'h0) q[2].push_back({30'h0, e});
        tick();
        rdone <= 1'b0;
        tick();
    endtask

    // Main sequence; each test ends with one line.
    initial begin
        logic [1:0] m;
        logic       on;
        int         c;
        void'($urandom(32'h3f0f));
        tick(2);
        arst_n <= 1'b1;
        tick(4);
        rd(8'h7c);
        wr(8'h7c, 4'hf, 32'hffff_ffff);
        rd(8'h7c);
        for (int k = 0; k < 6; k++) begin
            wr(8'h7c, 4'($urandom), $urandom);
            rd(8'h7c);
            chk("lower_mode", {21'h0, mreg[10:0]}, {21'h0, lmode});
        end
        wr(8'h78, 4'hf, 32'h0);
        rd(8'h78);
        rd(8'h7c);
        // A write offered while the clock enable is low must not land.
        ce <= 1'b0;
        wr_en <= 1'b1; addr <= 8'h7c; be <= 4'h7; wd <= ~mreg;
        tick();
        wr_en <= 1'b0; ce <= 1'b1;
        tick();
        rd(8'h7c);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            wr(8'h7c, 4'hf, {6'h0, 2'(k), 2'(k), 22'h0});
            for (int j = 0; j < 4; j++)
                col(j[0], j[1], k == 1 || (k != 2 && !j[1]));
        end
        $display("test precharge done");
        for (int k = 0; k < 2; k++) begin
            wr(8'h7c, 4'hf, {5'h0, k[0], 26'h0});
            actr <= 1'b1; cbusy <= 1'b1;
            tick();
            chk("act_grant", {31'h0, k[0]}, {31'h0, grant});
            cbusy <= 1'b0;
            tick();
            chk("act_grant", 32'h1, {31'h0, grant});
        end
        $display("test overlap done");
        for (int k = 0; k < 8; k++) begin
            wr(8'h7c, 4'hf, {10'h0, 2'(k), 20'h0});
            single <= k[2];
            tick();
            m  = (k[1:0] == 2'h2 && k[2]) ? 2'h1 : 2'(k);
            on = (m == 2'h1 || m == 2'h2);
            if (m != 2'h3) chk("integ_mode", {30'h0, m}, {30'h0, imode});
            chk("ecc_correct_en", {31'h0, on}, {31'h0, cor});
            cev <= 1'b1; uev <= 1'b1;
            if (on) q[3].push_back(32'h3);
            tick();
            cev <= 1'b0; uev <= 1'b0;
            tick();
        end
        $display("test integrity done");
        single <= 1'b0;
        wr(8'h7c, 4'hf, 32'h0810_0000);
        rdev(1'b1, 2'h2);
        chk("read_hold", 32'h1, {31'h0, hold});
        rdev(1'b1, 2'h1);
        rdev(1'b1, 2'h2);
        rdev(1'b0, 2'h0);
        wr(8'h7c, 4'hf, 32'h0010_0000);
        rdev(1'b1, 2'h1);
        $display("test retry done");
        wr(8'h7c, 4'hf, 32'h1000_0000);
        tick(3);
        chk("pair_cke", 32'h0, {28'h0, cke});
        want <= 4'h2;
        c = 0;
        while (cke[1] !== 1'b1 && c < 20) begin
            tick();
            c++;
        end
        c = 0;
        while (rdy[1] !== 1'b1 && c < 20) begin
            tick();
            c++;
        end
        chk("exit_cycles", dmc_pkg::PD_EXIT_CYC, c);
        tick(3);
        chk("pair_cke", 32'h2, {28'h0, cke});
        chk("late_use", 32'h0, late);
        want <= 4'h0;
        wr(8'h7c, 4'hf, 32'h0);
        tick(2);
        chk("pair_cke", 32'hf, {28'h0, cke});
        $display("test power down done");
        tick(3);
        end_sim();
    end
endmodule

//--- logic/dmc_mode_ctrl.sv
// Upper mode register of the DRAM controller with power-down, retry, overlap, precharge and ECC mode control.
// How it works
// - The top two revision bits of the mode register ignore writes and always read zero.
// - The init-complete bit is a plain read/write flag reset to zero that the hardware only stores.
// - With dynamic power-down on, a row pair goes to power-down through its clock enable once all its banks are closed and no access waits for it.
// - An access to a powered-down row pair first brings that pair out of power-down.
// - With retry on, a read hit by a double-bit error is reissued exactly once, and with retry off never.
// - With overlap on, activates may be issued while a column command is outstanding, otherwise not.
// - The write precharge field selects intelligent, always or never auto-precharge, with code 11 reserved.
// - The read precharge field selects intelligent, always or never auto-precharge, with code 11 reserved.
// - The integrity field selects no ECC, 72-bit ECC or x4 chip-fail ECC, with code 11 reserved.
// - In no-ECC mode nothing is corrected and no ECC error reaches the first and next error logs.
// - Chip-fail ECC chosen on a single channel behaves as 72-bit ECC.
`timescale 1ns/1ps
module dmc_mode_ctrl #(
    parameter int NUM_PAIRS = 4,
    parameter int EXIT_CYC  = dmc_pkg::PD_EXIT_CYC
) (
    // Clock, reset and enable.
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    input  wire logic                 ce,
    // Configuration access.
    input  wire logic                 cfg_wr_en,
    input  wire logic                 cfg_rd_en,
    input  wire logic [7:0]           cfg_addr,
    input  wire logic [3:0]           cfg_be,
    input  wire logic [31:0]          cfg_wdata,
    output logic      [31:0]          cfg_rdata,
    // Lower mode bits kept for the rest of the controller.
    output logic      [10:0]          lower_mode,
    // Channel setup.
    input  wire logic                 single_channel,
    // Row pair power-down.
    input  wire logic [NUM_PAIRS-1:0] pair_banks_idle,
    input  wire logic [NUM_PAIRS-1:0] pair_access_req,
    output logic      [NUM_PAIRS-1:0] pair_cke,
    output logic      [NUM_PAIRS-1:0] pair_ready,
    // Read completion and retry.
    input  wire logic                 rd_done,
    input  wire logic                 rd_ded,
    output logic                      retry_req,
    output logic                      read_hold,
    output logic                      ded_fatal,
    // Activate scheduling.
    input  wire logic                 act_req,
    input  wire logic                 col_busy,
    output logic                      act_grant,
    // Column command precharge decision.
    input  wire logic                 col_req,
    input  wire logic                 col_write,
    input  wire logic                 row_hit_pending,
    output logic                      ap_valid,
    output logic                      ap_flag,
    // ECC control and error logging.
    input  wire logic                 ecc_ce_evt,
    input  wire logic                 ecc_ue_evt,
    output logic      [1:0]           integ_mode,
    output logic                      ecc_correct_en,
    output logic                      log_ce,
    output logic                      log_ue
);

    logic rst_meta_r;
    logic rst_n;

    // The reset is released through two flip-flops so every flop leaves reset on the same edge.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n      <= rst_meta_r;
        end
    end

    logic [31:0] dram_controller_mode_r;
    logic [31:0] dram_controller_mode_nxt;
    logic [31:0] cfg_rdata_r;
    logic [31:0] cfg_rdata_nxt;
    logic        addr_hit;

    assign addr_hit = (cfg_addr[7:2] == dmc_pkg::MODE_OFFSET[7:2]);

    // Register writes merge the enabled byte lanes; masked bits never store, so the revision stays zero.
    always_comb begin
        logic [31:0] merged;
        merged = dram_controller_mode_r;
        for (int b = 0; b < 4; b++) begin
            if (cfg_be[b]) begin
                merged[b*8 +: 8] = cfg_wdata[b*8 +: 8];
            end
        end
        dram_controller_mode_nxt = dram_controller_mode_r;
        if (cfg_wr_en && addr_hit) begin
            dram_controller_mode_nxt = merged & dmc_pkg::MODE_WR_MASK;
        end
        cfg_rdata_nxt = cfg_rdata_r;
        if (cfg_rd_en) begin
            cfg_rdata_nxt = addr_hit ? dram_controller_mode_r : 32'h0000_0000;
        end
    end

    // Register storage; read data is held until the next read.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dram_controller_mode_r <= dmc_pkg::MODE_RESET;
            cfg_rdata_r            <= 32'h0000_0000;
        end else if (ce) begin
            dram_controller_mode_r <= dram_controller_mode_nxt;
            cfg_rdata_r            <= cfg_rdata_nxt;
        end
    end

    assign cfg_rdata  = cfg_rdata_r;
    assign lower_mode = dram_controller_mode_r[dmc_pkg::LOWER_W-1:0];

    // Field decode.
    logic            init_complete_flag;
    logic            pd_enable;
    logic            retry_en;
    logic            overlap_en;
    dmc_pkg::dmc_ap_t    wr_ap_policy;
    dmc_pkg::dmc_ap_t    rd_ap_policy;
    dmc_pkg::dmc_integ_t data_integrity_mode;
    dmc_pkg::dmc_integ_t integ_eff;
    logic            ecc_on;

    assign init_complete_flag  = dram_controller_mode_r[dmc_pkg::INIT_BIT];
    assign pd_enable           = dram_controller_mode_r[dmc_pkg::PDOWN_BIT];
    assign retry_en            = dram_controller_mode_r[dmc_pkg::RETRY_BIT];
    assign overlap_en          = dram_controller_mode_r[dmc_pkg::OVERLAP_BIT];
    assign wr_ap_policy        = dmc_pkg::dmc_ap_t'(dram_controller_mode_r[dmc_pkg::WR_AP_LSB +: 2]);
    assign rd_ap_policy        = dmc_pkg::dmc_ap_t'(dram_controller_mode_r[dmc_pkg::RD_AP_LSB +: 2]);
    assign data_integrity_mode = dmc_pkg::dmc_integ_t'(dram_controller_mode_r[dmc_pkg::INTEG_LSB +: 2]);

    // A single channel cannot spread a symbol over two channels, so chip-fail falls back to 72-bit ECC.
    always_comb begin
        integ_eff = data_integrity_mode;
        if (single_channel && data_integrity_mode == dmc_pkg::INTEG_CHIPFAIL) begin
            integ_eff = dmc_pkg::INTEG_ECC72;
        end
    end

    // The reserved integrity code is treated like no ECC, the safe reading of an illegal setting.
    assign ecc_on         = (integ_eff == dmc_pkg::INTEG_ECC72) || (integ_eff == dmc_pkg::INTEG_CHIPFAIL);
    assign integ_mode     = integ_eff;
    assign ecc_correct_en = ecc_on;

    // One sequencer per row pair.
    for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_pair
        dmc_pair_pwr #(
            .EXIT_CYC (EXIT_CYC)
        ) u_pair (
            .clock      (clock),
            .rst_n      (rst_n),
            .ce         (ce),
            .pd_enable  (pd_enable),
            .banks_idle (pair_banks_idle[g]),
            .access_req (pair_access_req[g]),
            .cke_o      (pair_cke[g]),
            .ready_o    (pair_ready[g])
        );
    end

    logic retry_out_r;
    logic retry_out_nxt;
    logic retry_req_r;
    logic retry_req_nxt;
    logic ded_fatal_r;
    logic ded_fatal_nxt;
    logic ded_seen;

    // A double-bit error only exists while ECC is checking the data.
    assign ded_seen = rd_done && rd_ded && ecc_on;

    // The reissued read is the next completion; reads stay held meanwhile so a second retry cannot start.
    always_comb begin
        retry_out_nxt = retry_out_r;
        retry_req_nxt = 1'b0;
        ded_fatal_nxt = 1'b0;
        if (rd_done) begin
            if (retry_out_r) begin
                retry_out_nxt = 1'b0;
                ded_fatal_nxt = ded_seen;
            end else if (ded_seen && retry_en) begin
                retry_out_nxt = 1'b1;
                retry_req_nxt = 1'b1;
            end else begin
                ded_fatal_nxt = ded_seen;
            end
        end
    end

    // Retry state registers.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            retry_out_r <= 1'b0;
            retry_req_r <= 1'b0;
            ded_fatal_r <= 1'b0;
        end else if (ce) begin
            retry_out_r <= retry_out_nxt;
            retry_req_r <= retry_req_nxt;
            ded_fatal_r <= ded_fatal_nxt;
        end
    end

    assign retry_req = retry_req_r;
    assign read_hold = retry_out_r;
    assign ded_fatal = ded_fatal_r;

    // Overlap trades a little bus ordering for earlier row opens.
    assign act_grant = act_req && (overlap_en || !col_busy);

    logic             ap_valid_r;
    logic             ap_valid_nxt;
    logic             ap_flag_r;
    logic             ap_flag_nxt;
    dmc_pkg::dmc_ap_t ap_policy;

    // The reserved policy code falls to the intelligent choice.
    always_comb begin
        ap_policy    = col_write ? wr_ap_policy : rd_ap_policy;
        ap_valid_nxt = col_req;
        ap_flag_nxt  = 1'b0;
        if (col_req) begin
            unique case (ap_policy)
                dmc_pkg::AP_ALWAYS: ap_flag_nxt = 1'b1;
                dmc_pkg::AP_NEVER:  ap_flag_nxt = 1'b0;
                dmc_pkg::AP_SMART:  ap_flag_nxt = !row_hit_pending;
                dmc_pkg::AP_RSVD:   ap_flag_nxt = !row_hit_pending;
            endcase
        end
    end

    // Precharge decision registers.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ap_valid_r <= 1'b0;
            ap_flag_r  <= 1'b0;
        end else if (ce) begin
            ap_valid_r <= ap_valid_nxt;
            ap_flag_r  <= ap_flag_nxt;
        end
    end

    assign ap_valid = ap_valid_r;
    assign ap_flag  = ap_flag_r;

    logic log_ce_r;
    logic log_ue_r;
    logic log_ce_nxt;
    logic log_ue_nxt;

    // Error events reach the logs only when ECC is active.
    always_comb begin
        log_ce_nxt = ecc_ce_evt && ecc_on;
        log_ue_nxt = ecc_ue_evt && ecc_on;
    end

    // Error log pulse registers.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            log_ce_r <= 1'b0;
            log_ue_r <= 1'b0;
        end else if (ce) begin
            log_ce_r <= log_ce_nxt;
            log_ue_r <= log_ue_nxt;
        end
    end

    assign log_ce = log_ce_r;
    assign log_ue = log_ue_r;

    // Checks tying outputs to the register settings.
    property p_rev_zero;
        @(posedge clock) disable iff (!rst_n || !ce)
        cfg_rd_en && addr_hit |=> cfg_rdata[31:30] == 2'h0;
    endproperty
    a_rev_zero: assert property (p_rev_zero) else $error("revision bits read nonzero");

    property p_init_store;
        @(posedge clock) disable iff (!rst_n || !ce)
        cfg_wr_en && addr_hit && cfg_be[3] ##1 !cfg_wr_en ##1 cfg_rd_en && addr_hit && !cfg_wr_en
            |=> cfg_rdata[dmc_pkg::INIT_BIT] == $past(cfg_wdata[dmc_pkg::INIT_BIT], 3);
    endproperty
    a_init_store: assert property (p_init_store) else $error("init flag did not read back");

    sequence s_first_ded;
        rd_done && rd_ded && ecc_on && retry_en && !read_hold;
    endsequence
    property p_retry_issue;
        @(posedge clock) disable iff (!rst_n || !ce)
        s_first_ded |=> retry_req && read_hold;
    endproperty
    a_retry_issue: assert property (p_retry_issue) else $error("double-bit error not retried");

    property p_retry_once;
        @(posedge clock) disable iff (!rst_n || !ce)
        read_hold && rd_done |=> !retry_req && !read_hold;
    endproperty
    a_retry_once: assert property (p_retry_once) else $error("read retried twice");

    property p_retry_off;
        @(posedge clock) disable iff (!rst_n || !ce)
        !retry_en && !read_hold |=> !retry_req;
    endproperty
    a_retry_off: assert property (p_retry_off) else $error("retry with retry disabled");

    property p_overlap;
        @(posedge clock) disable iff (!rst_n)
        act_grant && col_busy |-> overlap_en;
    endproperty
    a_overlap: assert property (p_overlap) else $error("activate overlapped a column command");

    property p_ap_fixed;
        @(posedge clock) disable iff (!rst_n || !ce)
        col_req && (ap_policy == dmc_pkg::AP_ALWAYS || ap_policy == dmc_pkg::AP_NEVER)
            |=> ap_valid && ap_flag == ($past(ap_policy) == dmc_pkg::AP_ALWAYS);
    endproperty
    a_ap_fixed: assert property (p_ap_fixed) else $error("fixed precharge policy ignored");

    property p_ap_smart;
        @(posedge clock) disable iff (!rst_n || !ce)
        col_req && ap_policy == dmc_pkg::AP_SMART |=> ap_flag == !$past(row_hit_pending);
    endproperty
    a_ap_smart: assert property (p_ap_smart) else $error("intelligent precharge wrong");

    property p_no_log;
        @(posedge clock) disable iff (!rst_n || !ce)
        integ_mode == dmc_pkg::INTEG_NONE |=> !log_ce && !log_ue;
    endproperty
    a_no_log: assert property (p_no_log) else $error("error logged without ECC");

    property p_chipfail_single;
        @(posedge clock) disable iff (!rst_n)
        single_channel && data_integrity_mode == dmc_pkg::INTEG_CHIPFAIL |-> integ_mode == dmc_pkg::INTEG_ECC72;
    endproperty
    a_chipfail_single: assert property (p_chipfail_single) else $error("chip-fail kept on one channel");

endmodule

//--- logic/dmc_pair_pwr.sv
// Power-down sequencer for one pair of DRAM rows, driving its clock enable.
`timescale 1ns/1ps
module dmc_pair_pwr #(
    parameter int EXIT_CYC = dmc_pkg::PD_EXIT_CYC
) (
    // Clock, reset and enable.
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic ce,
    // Control.
    input  wire logic pd_enable,
    input  wire logic banks_idle,
    input  wire logic access_req,
    // Pair state.
    output logic      cke_o,
    output logic      ready_o
);

    typedef enum logic [1:0] {
        PP_AWAKE = 2'b00,
        PP_DOWN  = 2'b01,
        PP_EXIT  = 2'b10
    } dmc_pp_state_t;

    dmc_pp_state_t state_r;
    dmc_pp_state_t state_nxt;
    logic [7:0]    cnt_r;
    logic [7:0]    cnt_nxt;
    logic          cke_r;
    logic          cke_nxt;

    // Next state: sleep only when every bank is closed and nothing waits for the pair.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        cke_nxt   = cke_r;
        unique case (state_r)
            PP_AWAKE: begin
                if (pd_enable && banks_idle && !access_req) begin
                    state_nxt = PP_DOWN;
                    cke_nxt   = 1'b0;
                end
            end
            PP_DOWN: begin
                if (access_req || !pd_enable) begin
                    state_nxt = PP_EXIT;
                    cke_nxt   = 1'b1;
                    cnt_nxt   = 8'(EXIT_CYC - 1);
                end
            end
            PP_EXIT: begin
                if (cnt_r == 8'h00) begin
                    state_nxt = PP_AWAKE;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            default: begin
                state_nxt = PP_AWAKE;
                cke_nxt   = 1'b1;
            end
        endcase
    end

    // State registers, frozen while the clock enable is low.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= PP_AWAKE;
            cnt_r   <= 8'h00;
            cke_r   <= 1'b1;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            cke_r   <= cke_nxt;
        end
    end

    assign cke_o   = cke_r;
    assign ready_o = (state_r == PP_AWAKE);

    // Checks on entry into and exit from power-down.
    property p_pd_entry;
        @(posedge clock) disable iff (!rst_n || !ce)
        $fell(cke_o) |-> $past(pd_enable) && $past(banks_idle) && !$past(access_req);
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("clock enable dropped while banks were busy");

    sequence s_wake_asked;
        (state_r == PP_DOWN) && access_req;
    endsequence
    sequence s_wake_done;
        cke_o && !ready_o ##[1:8] ready_o;
    endsequence
    property p_pd_exit;
        @(posedge clock) disable iff (!rst_n || !ce)
        s_wake_asked |=> s_wake_done;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("pair did not leave power-down on access");

endmodule

//--- logic/dmc_pkg.sv
// Package with the mode register layout, encodings and timing constants of the DRAM mode control block.
package dmc_pkg;

    // Register placement and reset value.
    localparam logic [7:0]  MODE_OFFSET     = 8'h7c;
    localparam logic [31:0] MODE_RESET      = 32'h0000_0008;
    // Bits 31:30 read as zero and bits 19:11 are reserved, so neither is ever stored.
    localparam logic [31:0] MODE_WR_MASK    = 32'h3ff0_07ff;

    // Field positions inside the mode register.
    localparam int FORMAT_LSB    = 30;
    localparam int INIT_BIT      = 29;
    localparam int PDOWN_BIT     = 28;
    localparam int RETRY_BIT     = 27;
    localparam int OVERLAP_BIT   = 26;
    localparam int WR_AP_LSB     = 24;
    localparam int RD_AP_LSB     = 22;
    localparam int INTEG_LSB     = 20;
    localparam int LOWER_W       = 11;

    // Auto-precharge policy codes.
    typedef enum logic [1:0] {
        AP_SMART  = 2'h0,
        AP_ALWAYS = 2'h1,
        AP_NEVER  = 2'h2,
        AP_RSVD   = 2'h3
    } dmc_ap_t;

    // Data integrity mode codes.
    typedef enum logic [1:0] {
        INTEG_NONE     = 2'h0,
        INTEG_ECC72    = 2'h1,
        INTEG_CHIPFAIL = 2'h2,
        INTEG_RSVD     = 2'h3
    } dmc_integ_t;

    // Power-down exit time; the cycle count rounds up at the clock rate.
    localparam int CLK_PERIOD_NS = 20;
    localparam int PD_EXIT_NS    = 30;
    localparam int PD_EXIT_CYC   = (PD_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage
